// >>> logic/tthr_pkg.sv
package tthr_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 5;

    // Modulation frame: eight slots, duty counted in slots
    localparam int               SLOT_NS      = 250;
    localparam int               SLOT_CYC     = SLOT_NS / CLK_PERIOD_NS;
    localparam logic [15:0]      SLOT_CYC_W   = 16'(SLOT_CYC);
    localparam int               DUTY_W       = 3;
    localparam logic [2:0]       FACTORY_DUTY = 3'h3;   // 3 of 8 slots on, fixed
    localparam int               OFF_MAX_NS   = 3000;
    localparam int               OFF_MAX_CYC  = OFF_MAX_NS / CLK_PERIOD_NS;

    // Clamp release hysteresis
    localparam int               HYST_NS      = 1000;
    localparam logic [15:0]      HYST_CYC     = 16'(HYST_NS / CLK_PERIOD_NS);

    // Frequency switch (bus stalled) and voltage step pacing
    localparam int               FSW_NS       = 5000;
    localparam logic [15:0]      FSW_CYC      = 16'(FSW_NS / CLK_PERIOD_NS);
    localparam int               VSTEP_NS     = 1000;
    localparam logic [15:0]      VSTEP_CYC    = 16'(VSTEP_NS / CLK_PERIOD_NS);

    // Minimum time from frequency drop before leaving the low operating point
    localparam int               MIN_ACT_US   = 1000;

    // Voltage select codes, one entry = 12.5 mV
    localparam int               VSC_W        = 6;
    localparam logic [5:0]       VSC_NORMAL   = 6'h0E;
    localparam logic [5:0]       VSC_LOW      = 6'h16;
    localparam logic [5:0]       VSC_ONE      = 6'h01;

    // Clock modulation control register layout
    localparam int               CMC_W        = 64;
    localparam int               CMC_FORCE    = 4;
    localparam int               CMC_DUTY_LSB = 1;
    localparam int               CMC_DUTY_MSB = 3;
    localparam logic [63:0]      CMC_RESET    = 64'h0;

    typedef enum logic [2:0] {
        FV_NORMAL,
        FV_FREQ_DN,
        FV_VOLT_DN,
        FV_LOW,
        FV_VOLT_UP,
        FV_FREQ_UP
    } tthr_fv_e;

endpackage

// >>> logic/tthr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tthr_ctrl
    import tthr_pkg::*;
#(
    parameter int MIN_ACT_CYC = MIN_ACT_US * 1000 / CLK_PERIOD_NS
) (
    input  wire logic             i_core_clk,           // Core clock, 200 MHz
    input  wire logic             i_rst,                // Async reset, active high
    input  wire logic             i_clk_en,             // Freezes all state when low
    input  wire logic             i_die_hot,            // Internal trip comparator
    input  wire logic             i_clamp_en,           // Clock-gating throttle enable
    input  wire logic             i_fv_en,              // Frequency-voltage throttle enable
    input  wire logic             i_evt_assert_en,      // Event on pin assertion
    input  wire logic             i_evt_deassert_en,    // Event on pin release
    input  wire logic             i_overtemp_flag_n_in, // Pin level seen
    output logic                  o_overtemp_flag_n_out,// Pin drive value
    output logic                  o_overtemp_flag_n_oe, // Pin drive enable
    input  wire logic             i_reg_wr,             // Control register write
    input  wire logic [63:0]      i_reg_wdata,          // Write data
    output logic [63:0]           o_reg_rdata,          // Register read value
    input  wire logic             i_irq_req,            // Edge-triggered interrupt in
    output logic                  o_irq_deliver,        // Interrupt handed to core
    output logic                  o_core_clk_on,        // Core clock gate enable
    output logic                  o_bus_block,          // Bus traffic stalled
    output logic                  o_freq_low,           // Low bus multiplier selected
    output logic [VSC_W-1:0]      o_vsc,                // Voltage select code
    output logic                  o_evt_assert,         // Pin asserted pulse
    output logic                  o_evt_deassert        // Pin released pulse
);

    // Control register: only force and duty bits are stored
    logic                 force_q;
    logic [DUTY_W-1:0]    duty_q;

    // Clamp state and hysteresis
    logic                 clamp_q;
    logic [15:0]          hyst_q;

    // Modulation frame
    logic [15:0]          slot_cnt_q;
    logic [DUTY_W-1:0]    phase_q;

    // Frequency-voltage sequencer
    tthr_fv_e             fv_q;
    tthr_fv_e             fv_d;
    logic [15:0]          fv_cnt_q;
    logic [15:0]          fv_cnt_d;
    logic [31:0]          act_cnt_q;
    logic [VSC_W-1:0]     vsc_d;

    // Interrupt pending and pin history
    logic                 irq_req_q;
    logic                 pend_q;
    logic                 pin_low_q;

    // Pin low from either end counts as heat; our own pull follows the die flag
    wire                  pin_low     = !i_overtemp_flag_n_in;
    wire                  hot_any     = i_die_hot || pin_low;
    wire                  clamp_set   = i_clamp_en && hot_any;
    wire                  hyst_done   = (hyst_q == 16'h0);
    wire                  clamp_clr   = !hot_any && hyst_done;

    // Duty select: factory value wins while clamp holds
    wire [DUTY_W-1:0]     force_duty  = (duty_q == 3'h0) ? FACTORY_DUTY : duty_q;
    wire [DUTY_W-1:0]     duty_sel    = clamp_q ? FACTORY_DUTY : force_duty;
    wire                  mod_act     = clamp_q || force_q;
    wire                  slot_end    = (slot_cnt_q == SLOT_CYC_W - 16'h1);
    wire                  clk_on_d    = !mod_act || (phase_q < duty_sel);

    // Frequency switch windows stall the bus
    wire                  in_switch   = (fv_d == FV_FREQ_DN) || (fv_d == FV_FREQ_UP);
    wire                  irq_rise    = i_irq_req && !irq_req_q;
    // Delivery lands with a clock-on cycle, never in the first cycle after a switch
    wire                  irq_ok      = clk_on_d && !in_switch && !o_bus_block;
    wire                  deliver     = pend_q && irq_ok;
    wire                  fv_done     = (fv_cnt_q == 16'h0);
    wire                  act_done    = (act_cnt_q == 32'h0);
    wire                  fv_hot      = i_fv_en && i_die_hot;

    // Control register write
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            force_q <= CMC_RESET[CMC_FORCE];
            duty_q  <= CMC_RESET[CMC_DUTY_MSB:CMC_DUTY_LSB];
        end else if (i_clk_en && i_reg_wr) begin
            force_q <= i_reg_wdata[CMC_FORCE];
            duty_q  <= i_reg_wdata[CMC_DUTY_MSB:CMC_DUTY_LSB];
        end
    end

    // Read-back; threshold never appears here
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= CMC_RESET;
        end else if (i_clk_en) begin
            o_reg_rdata <= {59'h0, force_q, duty_q, 1'b0};
        end
    end

    // Clamp engage and release; hysteresis reloads while any heat is seen
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            clamp_q <= 1'b0;
            hyst_q  <= 16'h0;
        end else if (i_clk_en) begin
            if (clamp_set) begin
                clamp_q <= 1'b1;
            end else if (clamp_clr) begin
                clamp_q <= 1'b0;
            end
            if (hot_any) begin
                hyst_q <= HYST_CYC;
            end else if (!hyst_done) begin
                hyst_q <= hyst_q - 16'h1;
            end
        end
    end

    // Slot timer and frame phase; frame restarts when modulation is idle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_cnt_q    <= 16'h0;
            phase_q       <= 3'h0;
            o_core_clk_on <= 1'b1;
        end else if (i_clk_en) begin
            if (!mod_act || slot_end) begin
                slot_cnt_q <= 16'h0;
            end else begin
                slot_cnt_q <= slot_cnt_q + 16'h1;
            end
            if (!mod_act) begin
                phase_q <= 3'h0;
            end else if (slot_end) begin
                phase_q <= phase_q + 3'h1;
            end
            o_core_clk_on <= clk_on_d;
        end
    end

    // Sequencer: frequency down, walk voltage, hold, walk back, frequency up
    always_comb begin
        fv_d     = fv_q;
        fv_cnt_d = fv_done ? 16'h0 : fv_cnt_q - 16'h1;
        vsc_d    = o_vsc;
        case (fv_q)
            FV_NORMAL: begin
                if (fv_hot) begin
                    fv_d     = FV_FREQ_DN;
                    fv_cnt_d = FSW_CYC;
                end
            end
            FV_FREQ_DN: begin
                if (fv_done) begin
                    fv_d     = FV_VOLT_DN;
                    fv_cnt_d = VSTEP_CYC;
                end
            end
            FV_VOLT_DN: begin
                if (o_vsc == VSC_LOW) begin
                    fv_d = FV_LOW;
                end else if (fv_done) begin
                    vsc_d    = o_vsc + VSC_ONE;
                    fv_cnt_d = VSTEP_CYC;
                end
            end
            FV_LOW: begin
                if (!i_die_hot && act_done) begin
                    fv_d     = FV_VOLT_UP;
                    fv_cnt_d = VSTEP_CYC;
                end
            end
            FV_VOLT_UP: begin
                if (o_vsc == VSC_NORMAL) begin
                    fv_d     = FV_FREQ_UP;
                    fv_cnt_d = FSW_CYC;
                end else if (fv_done) begin
                    vsc_d    = o_vsc - VSC_ONE;
                    fv_cnt_d = VSTEP_CYC;
                end
            end
            FV_FREQ_UP: begin
                if (fv_done) begin
                    fv_d = FV_NORMAL;
                end
            end
            default: begin
                fv_d = FV_NORMAL;
            end
        endcase
    end

    // Sequencer registers; minimum-activation count starts at frequency drop
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            fv_q        <= FV_NORMAL;
            fv_cnt_q    <= 16'h0;
            act_cnt_q   <= 32'h0;
            o_vsc       <= VSC_NORMAL;
            o_freq_low  <= 1'b0;
            o_bus_block <= 1'b0;
        end else if (i_clk_en) begin
            fv_q        <= fv_d;
            fv_cnt_q    <= fv_cnt_d;
            o_vsc       <= vsc_d;
            o_bus_block <= in_switch;
            if (fv_d == FV_FREQ_DN) begin
                o_freq_low <= 1'b1;
            end else if (fv_q == FV_FREQ_UP && fv_d == FV_NORMAL) begin
                o_freq_low <= 1'b0;
            end
            if (fv_q == FV_NORMAL) begin
                act_cnt_q <= 32'(MIN_ACT_CYC);
            end else if (!act_done) begin
                act_cnt_q <= act_cnt_q - 32'h1;
            end
        end
    end

    // Interrupt capture; a new edge in the delivery cycle stays pending
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_req_q     <= 1'b0;
            pend_q        <= 1'b0;
            o_irq_deliver <= 1'b0;
        end else if (i_clk_en) begin
            irq_req_q     <= i_irq_req;
            pend_q        <= irq_rise || (pend_q && !deliver);
            o_irq_deliver <= deliver;
        end
    end

    // Open-drain pin: pull low whenever the die is hot
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_overtemp_flag_n_oe  <= 1'b0;
            o_overtemp_flag_n_out <= 1'b1;
            pin_low_q             <= 1'b0;
            o_evt_assert          <= 1'b0;
            o_evt_deassert        <= 1'b0;
        end else if (i_clk_en) begin
            o_overtemp_flag_n_oe  <= i_die_hot;
            o_overtemp_flag_n_out <= !i_die_hot;
            pin_low_q             <= pin_low;
            o_evt_assert          <= i_evt_assert_en && pin_low && !pin_low_q;
            o_evt_deassert        <= i_evt_deassert_en && !pin_low && pin_low_q;
        end
    end

    // Helper: run of consecutive clock-off cycles, for the off-span bound
    logic [15:0] off_run_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            off_run_q <= 16'h0;
        end else if (i_clk_en) begin
            off_run_q <= o_core_clk_on ? 16'h0 : off_run_q + 16'h1;
        end
    end

    chk_clamp_engage: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_clamp_en && i_die_hot) |=> clamp_q)
        else $error("clamp not engaged on heat");

    chk_pin_holds_clamp: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_clamp_en && pin_low) |=> clamp_q)
        else $error("clamp dropped while pin low");

    chk_off_span_bound: assert property (@(posedge i_core_clk) disable iff (i_rst)
        off_run_q <= 16'(OFF_MAX_CYC))
        else $error("clock off span too long");

    chk_release_hyst: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(clamp_q) |-> ($past(hyst_q) == 16'h0 && !$past(i_die_hot)))
        else $error("clamp released before hysteresis");

    chk_factory_duty: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && clamp_q) |=> (o_core_clk_on == ($past(phase_q) < FACTORY_DUTY)))
        else $error("clamp not using factory duty");

    chk_force_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_reg_wr && i_reg_wdata[CMC_FORCE]) |=> mod_act)
        else $error("forced modulation not started");

    chk_switch_no_irq: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $past(o_bus_block) |-> !o_irq_deliver)
        else $error("interrupt delivered during switch");

    chk_vsc_single_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_vsc != $past(o_vsc)) |->
            ((o_vsc - $past(o_vsc)) == VSC_ONE || ($past(o_vsc) - o_vsc) == VSC_ONE))
        else $error("voltage code jumped more than one entry");

    chk_freq_after_volt: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_freq_low) |-> (o_vsc == VSC_NORMAL))
        else $error("frequency restored before voltage");

    chk_pin_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_die_hot) |=> (o_overtemp_flag_n_oe && !o_overtemp_flag_n_out))
        else $error("pin not driven while hot");

    // Helper: run of consecutive stalled cycles, for the switch length bound
    logic [15:0] blk_run_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            blk_run_q <= 16'h0;
        end else if (i_clk_en) begin
            blk_run_q <= o_bus_block ? blk_run_q + 16'h1 : 16'h0;
        end
    end

    chk_switch_span: assert property (@(posedge i_core_clk) disable iff (i_rst)
        blk_run_q <= FSW_CYC + 16'h1)
        else $error("bus stalled longer than one switch");

    chk_irq_clk_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_irq_deliver |-> (o_core_clk_on && !o_bus_block))
        else $error("interrupt delivered while clocks gated");

    chk_freq_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_freq_low) |-> (o_bus_block && o_vsc == VSC_NORMAL))
        else $error("voltage moved before frequency drop");

    chk_vsc_after_freq: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(o_vsc) |-> (o_freq_low && !o_bus_block))
        else $error("voltage code moved outside low frequency");

    chk_force_no_fv: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && !o_freq_low && !(i_fv_en && i_die_hot)) |=> !o_freq_low)
        else $error("frequency dropped without enabled heat");

endmodule

`default_nettype wire

// >>> dv/tthr_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// Board side: regulator taking voltage codes and a monitor that can pull the pin
module tthr_board_model
    import tthr_pkg::*;
(
    input  wire logic             i_core_clk,  // Core clock
    input  wire logic             i_rst,       // Async reset, active high
    input  wire logic             i_pull_req,  // Bench asks the monitor to pull low
    input  wire logic [VSC_W-1:0] i_vsc,       // Voltage select code from device
    output logic                  o_pull_oe,   // Monitor pulls the pin low
    output logic [7:0]            o_bad_steps  // Code moves larger than one entry
);
    logic [VSC_W-1:0] vsc_q;
    logic [7:0]       bad_q;
    logic             pull_q;
    logic             jump;

    // Regulator follows codes on the fly but only one table entry per change
    assign jump = (i_vsc != vsc_q) && (i_vsc != vsc_q + VSC_ONE)
                  && (vsc_q != i_vsc + VSC_ONE);

    // Monitor pull-down, registered like a board comparator output
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            vsc_q  <= VSC_NORMAL;
            bad_q  <= 8'h00;
            pull_q <= 1'b0;
        end else begin
            vsc_q  <= i_vsc;
            pull_q <= i_pull_req;
            if (jump) begin
                bad_q <= bad_q + 8'h01;
            end
        end
    end

    assign o_pull_oe   = pull_q;
    assign o_bad_steps = bad_q;
endmodule

`default_nettype wire

// >>> dv/tb_thermal_throttle_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_thermal_throttle_control
    import tthr_pkg::*;
;
    logic        core_clk, rst, clk_en, die_hot, clamp_en, fv_en, ev_a_en, ev_d_en;
    logic        flag_out, flag_oe, pull_oe, reg_wr, irq_req, irq_dlv, clk_on;
    logic        bus_blk, freq_low, ev_a, ev_d, pull_req, pin_n;
    logic [63:0] wdata, rdata;
    logic [5:0]  vsc;
    logic [7:0]  bad_steps;
    int          num_errors, checks_done;

    // Open-drain wire with pull-up: low when either party pulls
    assign pin_n = (flag_oe ? flag_out : 1'b1) & ~pull_oe;

    tthr_ctrl #(.MIN_ACT_CYC(50)) u_tthr_ctrl (
        .i_core_clk(core_clk), .i_rst(rst), .i_clk_en(clk_en), .i_die_hot(die_hot),
        .i_clamp_en(clamp_en), .i_fv_en(fv_en), .i_evt_assert_en(ev_a_en),
        .i_evt_deassert_en(ev_d_en), .i_overtemp_flag_n_in(pin_n),
        .o_overtemp_flag_n_out(flag_out), .o_overtemp_flag_n_oe(flag_oe),
        .i_reg_wr(reg_wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_irq_req(irq_req),
        .o_irq_deliver(irq_dlv), .o_core_clk_on(clk_on), .o_bus_block(bus_blk),
        .o_freq_low(freq_low), .o_vsc(vsc), .o_evt_assert(ev_a), .o_evt_deassert(ev_d));

    tthr_board_model u_tthr_board_model (
        .i_core_clk(core_clk), .i_rst(rst), .i_pull_req(pull_req), .i_vsc(vsc),
        .o_pull_oe(pull_oe), .o_bad_steps(bad_steps));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [63:0] v);
        reg_wr = 1'b1;
        wdata  = v;
        tick(1);
        reg_wr = 1'b0;
        tick(1);  // Edge between writes so strobe is never set twice in one step
    endtask

    // Counts clock-on cycles, longest off run and any frequency drop
    task automatic run(input int n, output int on, output int mx, output logic fl);
        int off;
        on = 0; mx = 0; off = 0; fl = 1'b0;
        repeat (n) begin
            tick(1);
            if (clk_on === 1'b1) begin
                on++;
                off = 0;
            end else begin
                off++;
            end
            if (off > mx) mx = off;
            if (freq_low !== 1'b0) fl = 1'b1;
        end
    endtask

    task automatic t_reset;
        chk({clk_on, bus_blk, freq_low, flag_oe, flag_out}, 64'h11);
        chk(vsc, VSC_NORMAL);
        chk(rdata, CMC_RESET);
    endtask

    // Clock enable low: a write must not land while state is frozen
    task automatic t_freeze;
        clk_en = 1'b0;
        wr(64'h10);
        tick(2);
        chk(rdata, CMC_RESET);
        chk(clk_on, 1'b1);
        clk_en = 1'b1;
        tick(2);
        chk(rdata, CMC_RESET);
    endtask

    // Forced modulation for every duty code, frequency-voltage mode enabled
    task automatic t_forced;
        int on, mx;
        logic fl;
        fv_en = 1'b1;
        wr(64'hFFFFFFFFFFFFFFFF);
        tick(2);
        chk(rdata, 64'h1E);
        for (int n = 0; n < 8; n++) begin
            wr(64'h10 | 64'(n << 1));
            tick(400);
            run(400, on, mx, fl);
            chk(on, (n == 0) ? 150 : n * 50);
            chk(fl, 1'b0);
        end
        wr(64'h0);
        fv_en = 1'b0;
    endtask

    // Temperature clamp with a competing forced duty, interrupt latching
    task automatic t_clamp;
        int on, mx, k;
        logic fl, seen;
        clamp_en = 1'b1;
        die_hot  = 1'b1;
        wr(64'h1E);
        tick(2);
        chk(flag_oe, 1'b1);
        tick(400);
        run(400, on, mx, fl);
        chk(on, 150);
        chk(mx <= OFF_MAX_CYC, 1'b1);
        k = 0;
        while (clk_on !== 1'b0 && k < 500) begin tick(1); k++; end
        irq_req = 1'b1;
        tick(1);
        irq_req = 1'b0;
        seen = 1'b0;
        while (clk_on === 1'b0 && k < 900) begin seen |= irq_dlv; tick(1); k++; end
        chk(seen, 1'b0);
        repeat (4) begin seen |= irq_dlv; tick(1); end
        chk(seen, 1'b1);
        wr(64'h0);
        die_hot = 1'b0;
        run(180, on, mx, fl);
        chk(on < 180, 1'b1);
        tick(int'(HYST_CYC) + 400);
        run(800, on, mx, fl);
        chk(on, 800);
        clamp_en = 1'b0;
    endtask

    // Pin driven with throttling off, events both ways, then external pull
    task automatic t_pin;
        int on, mx, k;
        logic fl;
        ev_a_en = 1'b1;
        ev_d_en = 1'b1;
        die_hot = 1'b1;
        k = 0;
        while (ev_a !== 1'b1 && k < 6) begin tick(1); k++; end
        chk(ev_a, 1'b1);
        chk({flag_oe, flag_out}, 64'h2);
        run(400, on, mx, fl);
        chk(on, 400);
        die_hot = 1'b0;
        k = 0;
        while (ev_d !== 1'b1 && k < 6) begin tick(1); k++; end
        chk(ev_d, 1'b1);
        clamp_en = 1'b1;
        pull_req = 1'b1;
        tick(400);
        run(400, on, mx, fl);
        chk(on, 150);
        chk(flag_oe, 1'b0);
        pull_req = 1'b0;
        tick(int'(HYST_CYC) + 410);
        run(400, on, mx, fl);
        chk(on, 400);
        clamp_en = 1'b0;
    endtask

    // Frequency-voltage walk down and back, interrupt during the switch
    task automatic t_fv;
        int k;
        logic seen, bad;
        fv_en   = 1'b1;
        die_hot = 1'b1;
        tick(2);
        chk({freq_low, bus_blk, vsc}, {2'b11, VSC_NORMAL});
        irq_req = 1'b1;
        tick(1);
        irq_req = 1'b0;
        k = 3; seen = 1'b0;
        while (bus_blk === 1'b1 && k < 2000) begin seen |= irq_dlv; tick(1); k++; end
        chk(seen, 1'b0);
        chk(k >= 1000 && k <= 1002, 1'b1);
        repeat (3) begin seen |= irq_dlv; tick(1); end
        chk(seen, 1'b1);
        k = 0; bad = 1'b0;
        while (vsc !== VSC_LOW && k < 2500) begin bad |= ~freq_low; tick(1); k++; end
        chk({bad, vsc}, {1'b0, VSC_LOW});
        die_hot = 1'b0;
        k = 0;
        while (vsc !== VSC_NORMAL && k < 2500) begin bad |= bus_blk; tick(1); k++; end
        chk({bad, freq_low, vsc}, {2'b01, VSC_NORMAL});
        k = 0;
        while (freq_low !== 1'b0 && k < 1500) begin tick(1); k++; end
        chk({freq_low, vsc}, {1'b0, VSC_NORMAL});
        chk(bad_steps, 8'h00);
        fv_en = 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog at 40k cycles, over twice the roughly 16k cycles the tests need
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        num_errors = 0; checks_done = 0;
        rst = 1'b1; clk_en = 1'b1; die_hot = 1'b0; clamp_en = 1'b0; fv_en = 1'b0;
        ev_a_en = 1'b0; ev_d_en = 1'b0; reg_wr = 1'b0; wdata = 64'h0;
        irq_req = 1'b0; pull_req = 1'b0;
        tick(6);
        rst = 1'b0;
        tick(1);
        t_reset();
        t_freeze();
        t_forced();
        t_clamp();
        t_pin();
        t_fv();
        report_and_stop();
    end
endmodule

`default_nettype wire
